// file: hdl/sar_adc_conversion_sequencer.sv
`timescale 1ns/1ps
`include "sar_seq_defs.svh"
// What this block does
// - Control write aborts, restarts unless channel off
// - Clock config write aborts conversion
// - Reset aborts and clears both result registers
// - Stop without async clock aborts conversion
// - Non-reset abort keeps last good results
// - Abort without a restart enters low-power state at once
// - 8-bit short: 18 ticks first, 16 later
// - 8-bit long: 38 ticks first, 36 later
// - 10-bit short: 21 ticks first, 19 later
// - 10-bit long: 41 ticks first, 39 later
// - Converter clock from chosen source, then divided
// - Sample window short or long by select
// - Round approximation to 8 or 10 bits
// - Codes monotonic with none missing
// - Async clock keeps converting through stop
// - Source select: bus, alternate or async
// - Divider divides by 1, 2, 4 or 8
// - Result transfer sets conversion done flag
module sar_adc_conversion_sequencer
    import sar_seq_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [1:0]  addr,
    input  wire logic [7:0]  wr_data,
    input  wire logic        wr_en,
    input  wire logic        rd_en,
    output logic      [7:0]  rd_data,
    input  wire logic        stop_mode,
    input  wire logic        alt_clock_pin,
    input  wire logic        async_clock_pin,
    input  wire logic        compare_high,
    output logic             analog_power,
    output logic             sample_enable,
    output logic      [10:0] dac_code,
    output logic             async_clock_run,
    output logic             conversion_done_flag
);

    // Largest divider count for the 1, 2, 4, 8 ratios
    function automatic logic [2:0] div_limit(input logic [1:0] sel);
        div_limit = {sel == 2'h3, sel[1], |sel};
    endfunction

    // Round to nearest and saturate, so the top code spans 1.5 LSB
    function automatic logic [9:0] round_sat(input logic [9:0] upper, input logic half);
        round_sat = (&upper) ? upper : upper + {9'h000, half};
    endfunction

    conv_state_e      state;
    conv_state_e      next_state;
    logic [4:0]       channel_select;
    logic             continuous;
    logic             input_clock_select;
    logic             async_clock_enable;
    logic [1:0]       clock_divider_select;
    logic             long_sample_select;
    logic             mode_10bit;
    logic [7:0]       result_high_reg;
    logic [7:0]       result_low_reg;
    wire  [1:0]       sync2;
    wire  [1:0]       sync3;
    logic             stop_prev;
    logic [2:0]       div_cnt;
    logic [5:0]       tcount;
    logic [8:0]       wcount;
    logic [1:0]       scount;
    logic             first;
    logic [10:0]      approx;
    logic [10:0]      trial_bit;

    // Reset values as constants, so that their fields can be picked apart
    localparam logic [7:0] sc_init = `SC_RESET;
    localparam logic [7:0] cc_init = `CC_RESET;

    // Clock pins pass two flops; a third flop per pin only feeds edge detection.
    // The comparator is a clocked macro on this clock and needs no synchroniser.
    wire [1:0] pins = {async_clock_pin, alt_clock_pin};
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : gen_sync
            logic s1;
            logic s2;
            logic s3;
            always_ff @(posedge clk) begin
                if (rst) begin
                    s1 <= 1'b0;
                    s2 <= 1'b0;
                    s3 <= 1'b0;
                end else begin
                    s1 <= pins[g];
                    s2 <= s1;
                    s3 <= s2;
                end
            end
            assign sync2[g] = s2;
            assign sync3[g] = s3;
        end
    endgenerate

    // Rising edges of the synchronised source clocks
    wire alt_rise   = sync2[0] & ~sync3[0];
    wire async_rise = sync2[1] & ~sync3[1];

    // Register port decode
    wire sc_write  = wr_en && addr == `REG_STATUS_CONTROL;
    wire cc_write  = wr_en && addr == `REG_CLOCK_CONFIG;
    wire low_read  = rd_en && addr == `REG_RESULT_LOW;
    wire start_req = sc_write
                     && wr_data[`SC_CHANNEL_MSB:`SC_CHANNEL_LSB] != `CHANNEL_OFF;
    wire stop_entry = stop_mode && !stop_prev && !async_clock_enable;
    wire abort     = sc_write || cc_write || stop_entry;

    // Source choice; async wins, then bus when input select is high
    wire source_edge = async_clock_enable ? async_rise
                     : (input_clock_select ? 1'b1 : alt_rise);
    wire conv_tick   = source_edge && div_cnt == div_limit(clock_divider_select);

    // Phase boundaries in converter ticks from the start of a conversion
    wire [5:0] lead_end   = first ? `FIRST_EXTRA_TICKS : 6'h00;
    wire [5:0] sample_len = `SHORT_SAMPLE_TICKS
                          + (long_sample_select ? `LONG_EXTRA_TICKS : 6'h00);
    wire [5:0] sample_end = lead_end + sample_len;
    wire [5:0] trial_end  = sample_end + (mode_10bit ? `TRIALS_10 : `TRIALS_8);
    wire [5:0] budget     = (mode_10bit ? `BASE_TICKS_10 : `BASE_TICKS_8)
                          + (long_sample_select ? `LONG_EXTRA_TICKS : 6'h00)
                          + lead_end;
    wire converting  = state == st_convert;
    wire in_sample   = converting && tcount >= lead_end && tcount < sample_end;
    wire in_trial    = converting && tcount >= sample_end && tcount < trial_end;
    wire trial_entry = converting && conv_tick && tcount == sample_end - 6'h01;
    wire last_tick   = converting && conv_tick && tcount == budget - 6'h01;
    wire transfer    = state == st_transfer && !abort;

    // Rounded results; the last trial bit decides the rounding
    wire [9:0] code10 = round_sat(approx[10:1], approx[0]);
    wire [9:0] round8 = round_sat({2'h3, approx[10:3]}, approx[2]);
    wire [9:0] code8  = {2'h0, round8[7:0]};
    wire [9:0] code   = mode_10bit ? code10 : code8;

    // Next state; any abort leaves the sequence at once
    always_comb begin
        next_state = state;
        if (abort) begin
            if (start_req)
                next_state = async_clock_enable ? st_warmup : st_convert;
            else
                next_state = st_idle;
        end else begin
            case (state)
                st_idle: next_state = st_idle;
                st_warmup: begin
                    if (wcount == 9'(`ASYNC_STARTUP_CYCLES - 1))
                        next_state = st_convert;
                end
                st_convert: begin
                    if (last_tick)
                        next_state = first ? st_sync : st_transfer;
                end
                st_sync: begin
                    if (scount == `SYNC_BUS_CYCLES - 2'h1)
                        next_state = st_transfer;
                end
                st_transfer: next_state = continuous ? st_convert : st_idle;
                default: next_state = st_idle;
            endcase
        end
    end

    // Sequencer state and counters
    always_ff @(posedge clk) begin
        if (rst) begin
            state  <= st_idle;
            tcount <= 6'h00;
            wcount <= 9'h000;
            scount <= 2'h0;
            first  <= 1'b0;
        end else begin
            state  <= next_state;
            wcount <= (state == st_warmup && !abort) ? wcount + 9'h001 : 9'h000;
            scount <= (state == st_sync && !abort) ? scount + 2'h1 : 2'h0;
            if (abort) begin
                tcount <= 6'h00;
                first  <= 1'b1;
            end else if (state == st_transfer) begin
                tcount <= 6'h00;
                first  <= 1'b0;
            end else if (converting && conv_tick && !last_tick) begin
                tcount <= tcount + 6'h01;
            end
        end
    end

    // Divider runs only while converting, so it starts fresh every conversion
    always_ff @(posedge clk) begin
        if (rst || abort || !converting)
            div_cnt <= 3'h0;
        else if (conv_tick)
            div_cnt <= 3'h0;
        else if (source_edge)
            div_cnt <= div_cnt + 3'h1;
    end

    // Successive approximation, one trial per converter tick
    always_ff @(posedge clk) begin
        if (rst) begin
            approx    <= 11'h000;
            trial_bit <= 11'h000;
            dac_code  <= 11'h000;
        end else if (trial_entry) begin
            approx    <= 11'h000;
            trial_bit <= 11'h400;
            dac_code  <= 11'h400;
        end else if (in_trial && conv_tick) begin
            // Keeping a bit only when input sits above it gives monotonic codes
            approx    <= approx | (compare_high ? trial_bit : 11'h000);
            trial_bit <= trial_bit >> 1;
            dac_code  <= (approx | (compare_high ? trial_bit : 11'h000)) | (trial_bit >> 1);
        end
    end

    // Software registers; a reset is the only thing that clears results
    always_ff @(posedge clk) begin
        if (rst) begin
            channel_select       <= sc_init[`SC_CHANNEL_MSB:`SC_CHANNEL_LSB];
            continuous           <= sc_init[`SC_CONTINUOUS];
            input_clock_select   <= cc_init[`CC_INPUT_SELECT];
            async_clock_enable   <= cc_init[`CC_ASYNC_ENABLE];
            clock_divider_select <= cc_init[`CC_DIV_MSB:`CC_DIV_LSB];
            long_sample_select   <= cc_init[`CC_LONG_SAMPLE];
            mode_10bit           <= cc_init[`CC_MODE_10BIT];
            result_high_reg      <= `RESULT_RESET;
            result_low_reg       <= `RESULT_RESET;
            stop_prev            <= 1'b0;
        end else begin
            stop_prev <= stop_mode;
            if (sc_write) begin
                channel_select <= wr_data[`SC_CHANNEL_MSB:`SC_CHANNEL_LSB];
                continuous     <= wr_data[`SC_CONTINUOUS];
            end
            if (cc_write) begin
                input_clock_select   <= wr_data[`CC_INPUT_SELECT];
                async_clock_enable   <= wr_data[`CC_ASYNC_ENABLE];
                clock_divider_select <= wr_data[`CC_DIV_MSB:`CC_DIV_LSB];
                long_sample_select   <= wr_data[`CC_LONG_SAMPLE];
                mode_10bit           <= wr_data[`CC_MODE_10BIT];
            end
            // Only a finished, unaborted conversion reaches the results
            if (transfer) begin
                result_high_reg <= {6'h00, code[9:8]};
                result_low_reg  <= code[7:0];
            end
        end
    end

    // Done flag: a transfer in the same cycle as a clearing read wins
    always_ff @(posedge clk) begin
        if (rst)
            conversion_done_flag <= 1'b0;
        else if (transfer)
            conversion_done_flag <= 1'b1;
        else if (sc_write || low_read)
            conversion_done_flag <= 1'b0;
    end

    // Power and async run follow the next state, sample enable the current phase masked by abort, so an abort without a restart powers down at that edge
    always_ff @(posedge clk) begin
        if (rst) begin
            analog_power    <= 1'b0;
            async_clock_run <= 1'b0;
            sample_enable   <= 1'b0;
        end else begin
            analog_power    <= next_state != st_idle;
            async_clock_run <= next_state != st_idle && async_clock_enable;
            sample_enable   <= in_sample && !abort;
        end
    end

    // Read data stands in the cycle after the strobe only
    wire [7:0] read_mux =
        (addr == `REG_STATUS_CONTROL) ? {conversion_done_flag, 1'b0, continuous, channel_select}
      : (addr == `REG_RESULT_HIGH)    ? result_high_reg
      : (addr == `REG_RESULT_LOW)     ? result_low_reg
      : {2'h0, mode_10bit, long_sample_select, clock_divider_select,
         async_clock_enable, input_clock_select};

    always_ff @(posedge clk) begin
        if (rst)
            rd_data <= 8'h00;
        else
            rd_data <= rd_en ? read_mux : 8'h00;
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    chk_write_restart: assert property (
        start_req |=> (state == st_convert || state == st_warmup) && tcount == 6'h00 && first)
        else $error("control write did not restart");

    chk_channel_off: assert property (
        sc_write && !start_req |=> state == st_idle && !analog_power)
        else $error("channel off write did not idle");

    chk_clock_write: assert property (
        cc_write && !sc_write |=> state == st_idle)
        else $error("clock write did not abort");

    chk_reset_results: assert property (@(posedge clk) disable iff (1'b0)
        rst |=> result_high_reg == `RESULT_RESET && result_low_reg == `RESULT_RESET
                && state == st_idle)
        else $error("reset left results");

    // A new control write may follow at once, so power is judged in the first cycle only
    chk_stop_abort: assert property (
        stop_entry && !wr_en |=> state == st_idle && !analog_power && !async_clock_run)
        else $error("stop did not abort");

    chk_abort_keeps: assert property (
        abort |=> $stable(result_low_reg) && $stable(result_high_reg))
        else $error("abort changed results");

    chk_power_down: assert property (
        abort && !start_req |=> !analog_power && !async_clock_run && !sample_enable)
        else $error("abort left power on");

    chk_sync_delay: assert property (disable iff (rst || abort)
        last_tick && first |=> (state == st_sync) [*3] ##1 state == st_transfer)
        else $error("bus sync not three cycles");

    chk_later_budget: assert property (disable iff (rst || abort)
        state == st_transfer && continuous |=> converting && !first && tcount == 6'h00)
        else $error("continuous restart wrong");

    chk_done_set: assert property (
        transfer |=> conversion_done_flag && result_low_reg == $past(code[7:0]))
        else $error("done flag not set on transfer");

    chk_stay_idle: assert property (
        state == st_idle && !sc_write |=> state == st_idle)
        else $error("conversion started without write");

    chk_async_stop: assert property (
        stop_mode && async_clock_enable && converting && !wr_en |=> state != st_idle)
        else $error("async conversion stopped in stop");

endmodule

// file: hdl/sar_seq_defs.svh
`ifndef SAR_SEQ_DEFS_SVH
`define SAR_SEQ_DEFS_SVH

// Register indices on the plain register port
`define REG_STATUS_CONTROL  2'h0
`define REG_RESULT_HIGH     2'h1
`define REG_RESULT_LOW      2'h2
`define REG_CLOCK_CONFIG    2'h3

// Status-and-control fields
`define SC_CHANNEL_MSB      4
`define SC_CHANNEL_LSB      0
`define SC_CONTINUOUS       5
`define SC_DONE             7
`define CHANNEL_OFF         5'h1f

// Clock configuration fields
`define CC_INPUT_SELECT     0
`define CC_ASYNC_ENABLE     1
`define CC_DIV_LSB          2
`define CC_DIV_MSB          3
`define CC_LONG_SAMPLE      4
`define CC_MODE_10BIT       5

// Reset values
`define SC_RESET            8'h1f
`define CC_RESET            8'h00
`define RESULT_RESET        8'h00

// Converter clock budgets, in converter clock ticks; the bus sync count in bus clock cycles
`define SHORT_SAMPLE_TICKS  6'h04
`define LONG_EXTRA_TICKS    6'h14
`define FIRST_EXTRA_TICKS   6'h02
`define BASE_TICKS_8        6'h10
`define BASE_TICKS_10       6'h13
`define TRIALS_8            6'h09
`define TRIALS_10           6'h0b
`define SYNC_BUS_CYCLES     2'h3

// Asynchronous clock start-up time
`define CLK_PERIOD_PS       20000
`define ASYNC_STARTUP_PS    5000000
`define ASYNC_STARTUP_CYCLES (`ASYNC_STARTUP_PS / `CLK_PERIOD_PS)

`endif

// file: hdl/sar_seq_pkg.sv
package sar_seq_pkg;

    // Sequencer states; the converting state is split into phases by a tick count
    typedef enum logic [2:0] {
        st_idle,
        st_warmup,
        st_convert,
        st_sync,
        st_transfer
    } conv_state_e;

endpackage

// file: dv/analog_front_model.sv
`timescale 1ns/1ps
// Comparator beside the trial DAC; level is the held input in half-LSB steps of 10 bits
module analog_front_model (
    input  wire logic        analog_power,
    input  wire logic [10:0] dac_code,
    input  wire logic [10:0] level,
    output logic             compare_high
);
    // Unpowered, the comparator gives no usable answer, so it follows the code's LSB
    assign compare_high = analog_power ? (level >= dac_code) : dac_code[0];
endmodule

// file: dv/sar_adc_conversion_sequencer_tb_top.sv
`timescale 1ns/1ps
`define check(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin miscompares++; \
    $display("BAD %s expected %0h seen %0h", nm, ex, got); end end
module sar_adc_conversion_sequencer_tb_top;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [1:0]  addr = 2'h0;
    logic [7:0]  wr_data = 8'h00;
    logic        wr_en = 1'b0;
    logic        rd_en = 1'b0;
    logic        stop_mode = 1'b0;
    logic        alt_clock_pin = 1'b0;
    logic        async_clock_pin = 1'b0;
    logic [10:0] level = 11'h000;
    logic [7:0]  rd_data;
    logic        compare_high;
    logic        analog_power;
    logic        sample_enable;
    logic [10:0] dac_code;
    logic        async_clock_run;
    logic        conversion_done_flag;
    logic [7:0]  d;
    logic [7:0]  lo;
    logic [7:0]  hi;
    int          miscompares = 0;
    int          n_checks = 0;
    int          cycles = 0;
    int          cyc;
    int          samp;
    int          ar;
    int          tk[4] = '{18, 38, 21, 41};

    // Bus clock, plus two free-running source pins unrelated to it; their
    // half periods keep every pin edge off a rising edge of the bus clock
    always #10 clk = ~clk;
    always #40 alt_clock_pin = ~alt_clock_pin;
    always #32 async_clock_pin = ~async_clock_pin;

    sar_adc_conversion_sequencer dut (
        .clk                  (clk),
        .rst                  (rst),
        .addr                 (addr),
        .wr_data              (wr_data),
        .wr_en                (wr_en),
        .rd_en                (rd_en),
        .rd_data              (rd_data),
        .stop_mode            (stop_mode),
        .alt_clock_pin        (alt_clock_pin),
        .async_clock_pin      (async_clock_pin),
        .compare_high         (compare_high),
        .analog_power         (analog_power),
        .sample_enable        (sample_enable),
        .dac_code             (dac_code),
        .async_clock_run      (async_clock_run),
        .conversion_done_flag (conversion_done_flag)
    );

    analog_front_model front (
        .analog_power (analog_power),
        .dac_code     (dac_code),
        .level        (level),
        .compare_high (compare_high)
    );

    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Hang guard: the whole sequence needs well under a tenth of this
    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            miscompares++;
            conclude();
        end
    end

    task automatic wr(input logic [1:0] a, input logic [7:0] v);
        @(posedge clk);
        addr    <= a;
        wr_data <= v;
        wr_en   <= 1'b1;
        @(posedge clk);
        wr_en   <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [1:0] a, output logic [7:0] v);
        @(posedge clk);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1 v = rd_data;
    endtask

    // Counts cycles up to the done flag, with sample and async-run cycles on the way
    task automatic run(input int lim);
        cyc = 0;
        samp = 0;
        ar = 0;
        while (conversion_done_flag !== 1'b1 && cyc < lim) begin
            @(posedge clk);
            #1;
            cyc++;
            if (sample_enable === 1'b1)
                samp++;
            if (async_clock_run === 1'b1)
                ar++;
        end
    endtask

    // Rounded result: 11 trials for 10 bits, 9 for 8 bits, both saturate at full scale
    function automatic logic [9:0] expect_code(input logic m10, input logic [10:0] v);
        logic [11:0] r;
        r = m10 ? ({1'b0, v} + 12'h001) >> 1 : ({3'h0, v[10:2]} + 12'h001) >> 1;
        if (m10 && r > 12'h3ff)
            r = 12'h3ff;
        if (!m10 && r > 12'h0ff)
            r = 12'h0ff;
        return r[9:0];
    endfunction

    // Start one conversion and judge its length, window, flag and result
    task automatic finish(input int lo_lim, input int hi_lim, input int smp, input logic stp,
                          input logic [9:0] expv);
        wr(2'h0, 8'h00);
        if (stp) begin
            @(posedge clk);
            stop_mode <= 1'b1;
        end
        run(hi_lim + 50);
        `check("time max", 1'b1, cyc <= hi_lim)
        `check("time min", 1'b1, cyc >= lo_lim)
        if (smp >= 0)
            `check("sample window", smp, samp)
        if (stp)
            `check("async run", 1'b1, ar > 0)
        @(posedge clk);
        stop_mode <= 1'b0;
        rd(2'h0, d);
        `check("done flag", 1'b1, d[7])
        rd(2'h2, lo);
        rd(2'h1, hi);
        `check("result", expv, {hi[1:0], lo})
        `check("done cleared", 1'b0, conversion_done_flag)
    endtask

    // Abort mid conversion: 0 clock write, 1 stop entry, 2 channel off, 3 reset
    task automatic abort_case(input int k);
        wr(2'h3, 8'h21);
        level = 11'h190;
        finish(20, 27, 4, 1'b0, 10'h0c8);
        level = 11'h3e8;
        wr(2'h0, 8'h00);
        repeat (8) @(posedge clk);
        case (k)
            0: wr(2'h3, 8'h21);
            1: begin
                @(posedge clk);
                stop_mode <= 1'b1;
            end
            2: wr(2'h0, 8'h1f);
            default: begin
                @(posedge clk);
                rst <= 1'b1;
                repeat (3) @(posedge clk);
                rst <= 1'b0;
            end
        endcase
        repeat (2) @(posedge clk);
        #1;
        `check("power off", 1'b0, analog_power)
        repeat (100) @(posedge clk);
        #1;
        `check("stays idle", 1'b0, analog_power | conversion_done_flag)
        rd(2'h2, lo);
        rd(2'h1, hi);
        `check("kept result", (k == 3) ? 10'h000 : 10'h0c8, {hi[1:0], lo})
        @(posedge clk);
        stop_mode <= 1'b0;
        $display("test abort %0d done", k);
    endtask

    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        rd(2'h0, d);
        `check("status reset", 8'h1f, d)
        rd(2'h3, d);
        `check("clock cfg reset", 8'h00, d)
        rd(2'h2, lo);
        rd(2'h1, hi);
        `check("result reset", 16'h0000, {hi, lo})
        `check("idle power", 1'b0, analog_power)
        $display("test reset values done");
        // Each width and sample length on the bus clock, divide by one
        for (int m = 0; m < 4; m++) begin
            level = 11'h5a7 + 11'(m);
            wr(2'h3, {2'b00, m[1], m[0], 4'b0001});
            finish(tk[m] - 1, tk[m] + 6, m[0] ? 24 : 4, 1'b0, expect_code(m[1], level));
        end
        $display("test modes done");
        // Code ends and edges; the top 8-bit code must saturate, not wrap
        for (int i = 0; i < 6; i++) begin
            level = (i < 3) ? 11'(i) : 11'h7fc + 11'(i - 3);
            wr(2'h3, {2'b00, i[0], 5'b00001});
            finish(i[0] ? 20 : 17, i[0] ? 27 : 24, 4, 1'b0, expect_code(i[0], level));
        end
        $display("test code sweep done");
        // Dividers 2, 4 and 8 stretch every tick of the bus clock
        for (int v = 1; v < 4; v++) begin
            level = 11'h333;
            wr(2'h3, {4'h0, 2'(v), 2'b01});
            finish(18 * (1 << v) - (1 << v), 18 * (1 << v) + 6, 4 * (1 << v), 1'b0,
                   expect_code(1'b0, level));
        end
        $display("test divider done");
        wr(2'h3, 8'h00);
        finish(18 * 4 - 4, 18 * 4 + 10, -1, 1'b0, expect_code(1'b0, level));
        $display("test alternate source done");
        wr(2'h3, 8'h02);
        finish(250 + 50, 250 + 18 * 4 + 10, -1, 1'b1, expect_code(1'b0, level));
        $display("test async source in stop done");
        for (int k = 0; k < 4; k++)
            abort_case(k);
        // Second status write restarts the count from itself
        wr(2'h3, 8'h21);
        level = 11'h2bc;
        wr(2'h0, 8'h00);
        repeat (10) @(posedge clk);
        finish(20, 27, 4, 1'b0, 10'h15e);
        $display("test restart done");
        // Continuous: later conversions skip the lead ticks and the bus sync
        level = 11'h190;
        wr(2'h0, 8'h20);
        run(80);
        rd(2'h2, lo);
        run(80);
        `check("next conv time", 1'b1, cyc >= 15 && cyc <= 21)
        `check("cont result", 8'hc8, lo)
        wr(2'h0, 8'h1f);
        $display("test continuous done");
        conclude();
    end
endmodule
